/* verilog/smd_defines.svh */
// Constants for the servo monitor display block
`ifndef SMD_DEFINES_SVH
`define SMD_DEFINES_SVH
// ==================================================
// Timing
`define SMD_CLK_MHZ      100
`define SMD_HOLD_MS      1000
`define SMD_PEAK_MS      2000
`define SMD_FREQ_WIN_MS  10
`define SMD_BLINK_MS     500
// ==================================================
// Item numbers
`define SMD_IT_SEQ       5'h00
`define SMD_IT_FIRST     5'h01
`define SMD_IT_LAST      5'h1c
`define SMD_IT_FBSPD     5'h01
`define SMD_IT_CMDSPD    5'h02
`define SMD_IT_CMDTRQ    5'h03
`define SMD_IT_CURR      5'h04
`define SMD_IT_PEAK      5'h05
`define SMD_IT_EFFTRQ    5'h06
`define SMD_IT_FBPOS     5'h07
`define SMD_IT_CMDPOS    5'h08
`define SMD_IT_DEV       5'h09
`define SMD_IT_FREQ      5'h0a
`define SMD_IT_FBCUM     5'h0b
`define SMD_IT_CMDCUM    5'h0c
`define SMD_IT_LSZ       5'h0d
`define SMD_IT_INERT     5'h0e
`define SMD_IT_VMAX      5'h0f
`define SMD_IT_VMIN      5'h10
`define SMD_IT_VREF      5'h11
`define SMD_IT_TORQUE_REF_ANALOG_IN      5'h12
`define SMD_IT_SEQIN     5'h13
`define SMD_IT_SEQOUT    5'h14
`define SMD_IT_OL        5'h15
`define SMD_IT_BRK       5'h16
`define SMD_IT_POWER     5'h17
`define SMD_IT_TEMP      5'h18
`define SMD_IT_OVSH      5'h19
`define SMD_IT_SETTLE    5'h1a
`define SMD_IT_RES1      5'h1b
`define SMD_IT_RES2      5'h1c
// ==================================================
// Display limits
`define SMD_FREQ_LIM     41'sh00000002710
`define SMD_INERT_MAX    41'sh00000000bb8
`define SMD_VDC_MAX      41'sh000000001f4
`define SMD_AIN_LIM      41'sh0000000041a
`define SMD_PCT_100      41'sh00000000064
`define SMD_POWER_MAX    41'sh00000000384
`define SMD_TEMP_MAX     41'sh00000000078
`define SMD_SETTLE_MAX   41'sh00000002710
`define SMD_RES_MIN      41'sh00000000064
`define SMD_RES_MAX      41'sh000000007d0
`define SMD_RES_NONE     41'sh00000000fa0
`define SMD_HALF_DIV     41'sh000000186a0
`define SMD_BRK_KW10_MIN 8'h04
`define SMD_BRK_INTERNAL 2'h1
`define SMD_TAG_NONE     2'h0
`define SMD_TAG_HIGH     2'h1
`define SMD_TAG_LOW      2'h2
`endif

/* verilog/smd_pkg.sv */
// Types shared by the servo monitor display block
`default_nettype none
package smd_pkg;
  // Keypad view
  typedef enum logic [1:0] {ViewSeq, ViewLabel, ViewData} smd_view_t;
endpackage : smd_pkg
`default_nettype wire

/* verilog/smd_monitor.sv */
// Monitor-mode readout, pulse counters and keypad control for a servo amplifier
`timescale 1ns/1ps
`default_nettype none
`include "smd_defines.svh"
module smd_monitor
  import smd_pkg::*;
#(
  parameter int HOLD_CYC     = `SMD_HOLD_MS * 1000 * `SMD_CLK_MHZ,
  parameter int PEAK_CYC     = `SMD_PEAK_MS * 1000 * `SMD_CLK_MHZ,
  parameter int FREQ_WIN_CYC = `SMD_FREQ_WIN_MS * 1000 * `SMD_CLK_MHZ,
  parameter int BLINK_CYC    = `SMD_BLINK_MS * 1000 * `SMD_CLK_MHZ
) (
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               nrst,
  // Keypad pins
  input  wire logic               keyUp,
  input  wire logic               keyDown,
  input  wire logic               keyShift,
  input  wire logic               menu_back_key,
  // Command pulse input pins and mode
  input  wire logic               pulseInA,
  input  wire logic               pulseInB,
  input  wire logic               pulseQuadMode,
  // Motor control core measurements
  input  wire logic signed [15:0] fbSpeed,
  input  wire logic signed [15:0] cmdSpeed,
  input  wire logic signed [15:0] cmdTorque,
  input  wire logic signed [15:0] motorCurrent,
  input  wire logic signed [15:0] effTorque,
  input  wire logic               encStepFwd,
  input  wire logic               encStepRev,
  input  wire logic               gearEnable,
  input  wire logic        [15:0] gearNum,
  input  wire logic        [15:0] gearDen,
  input  wire logic signed [39:0] cmdPosition,
  input  wire logic signed [39:0] cmdPosPulses,
  input  wire logic signed [39:0] overshoot,
  input  wire logic               homingActive,
  input  wire logic               homeSwitch,
  input  wire logic               indexPulse,
  input  wire logic               indexEnable,
  input  wire logic        [15:0] inertiaRatio,
  input  wire logic        [15:0] dcLinkVolt,
  input  wire logic signed [15:0] speedRefIn,
  input  wire logic signed [15:0] torque_ref_analog_in,
  input  wire logic        [15:0] sequence_input,
  input  wire logic        [15:0] sequenceOutput,
  input  wire logic        [15:0] overload_thermal,
  input  wire logic        [15:0] brakeRatio,
  input  wire logic        [7:0]  motorKw10,
  input  wire logic        [1:0]  braking_resistor_select,
  input  wire logic signed [15:0] motorPower,
  input  wire logic        [15:0] motorTemp,
  input  wire logic        [15:0] settleTime,
  input  wire logic        [15:0] resFreq1,
  input  wire logic        [15:0] resFreq2,
  input  wire logic               res1Found,
  input  wire logic               res2Found,
  input  wire logic        [4:0]  power_on_display_select,
  // Display and alarm outputs
  output logic             [4:0]  dispItem,
  output logic                    dispLabel,
  output logic                    dispSeqMode,
  output logic             [16:0] dispData,
  output logic                    dispMinus,
  output logic             [1:0]  dispHalfTag,
  output logic             [15:0] dispSegments,
  output logic                    overloadAlarm,
  output logic                    brakeOverheatAlarm
);

  // ==================================================
  // Pin synchronisers
  // A pin change counts once the second and third stages agree.
  logic [5:0] pinRaw;
  logic [5:0] sync1_q, sync2_q, sync3_q, pin_q;
  assign pinRaw = {pulseInB, pulseInA, menu_back_key, keyShift, keyDown, keyUp};
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : gSync
      always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
          sync3_q[gi] <= 1'b0;
          pin_q[gi]   <= 1'b0;
        end else begin
          sync1_q[gi] <= pinRaw[gi];
          sync2_q[gi] <= sync1_q[gi];
          sync3_q[gi] <= sync2_q[gi];
          if (sync2_q[gi] == sync3_q[gi]) pin_q[gi] <= sync3_q[gi];
        end
      end
    end
  endgenerate

  // Filtered pin levels, one cycle delayed copies for edges
  logic [5:0] pinDly_q;
  wire  upRise    = pin_q[0] & ~pinDly_q[0];
  wire  downRise  = pin_q[1] & ~pinDly_q[1];
  wire  shiftRise = pin_q[2] & ~pinDly_q[2];
  wire  backRise  = pin_q[3] & ~pinDly_q[3];
  wire  bothArrow = pin_q[0] & pin_q[1];

  // ==================================================
  // Keypad view control
  smd_view_t  view_q;
  logic [4:0] item_q;
  logic       boot_q, halfHigh_q, clearDone_q;
  logic [26:0] shiftCnt_q, bothCnt_q;
  wire  shiftLong = pin_q[2] && (shiftCnt_q == 27'(HOLD_CYC - 1));
  wire  bothLong  = bothArrow && (bothCnt_q == 27'(HOLD_CYC - 1)) && !clearDone_q;
  wire  inData    = (view_q == ViewData);
  wire  clrFbCum  = inData && bothLong && (item_q == `SMD_IT_FBCUM);
  wire  clrCmdCum = inData && bothLong && (item_q == `SMD_IT_CMDCUM);
  wire  bootValid = (power_on_display_select <= `SMD_IT_LAST);
  wire [4:0] itemNext = (item_q == `SMD_IT_LAST) ? `SMD_IT_FIRST : item_q + 5'h01;
  wire [4:0] itemPrev = (item_q == `SMD_IT_FIRST) ? `SMD_IT_LAST : item_q - 5'h01;

  // The shift hold timer saturates and bothCnt_q runs on; shiftLong stays high while shift is held, and clearDone_q lets bothLong fire only once
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pinDly_q    <= 6'h00;
      shiftCnt_q  <= 27'h0000000;
      bothCnt_q   <= 27'h0000000;
      clearDone_q <= 1'b0;
    end else begin
      pinDly_q    <= pin_q;
      shiftCnt_q  <= !pin_q[2] ? 27'h0000000 : (shiftLong ? shiftCnt_q : shiftCnt_q + 27'h1);
      bothCnt_q   <= !bothArrow ? 27'h0000000 : (bothLong ? bothCnt_q : bothCnt_q + 27'h1);
      clearDone_q <= bothArrow && (clearDone_q || bothLong);
    end
  end

  // View state machine; power-on setting taken on the first edge after release
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      boot_q     <= 1'b1;
      view_q     <= ViewSeq;
      item_q     <= `SMD_IT_SEQ;
      halfHigh_q <= 1'b0;
    end else if (boot_q) begin
      boot_q <= 1'b0;
      item_q <= bootValid ? power_on_display_select : `SMD_IT_SEQ;
      view_q <= (bootValid && power_on_display_select != `SMD_IT_SEQ)
                ? ViewLabel : ViewSeq;
    end else begin
      unique case (view_q)
        ViewSeq: if (backRise) begin
          view_q <= ViewLabel;
          item_q <= `SMD_IT_FIRST;
        end
        ViewLabel: begin
          if (backRise) begin
            view_q <= ViewSeq;
            item_q <= `SMD_IT_SEQ;
          end else if (shiftLong) begin
            view_q     <= ViewData;
            halfHigh_q <= 1'b0;
          end else if (upRise && !pin_q[1]) begin
            item_q <= itemNext;
          end else if (downRise && !pin_q[0]) begin
            item_q <= itemPrev;
          end
        end
        ViewData: begin
          if (backRise) view_q <= ViewLabel;
          else if (shiftRise) halfHigh_q <= ~halfHigh_q;
        end
      endcase
    end
  end

  // ==================================================
  // Pulse counters
  // Command pulse decode: fwd/rev pulses on A/B, or every quadrature edge
  logic [1:0] abPrev_q;
  wire  [1:0] abNow = {pin_q[4], pin_q[5]};
  wire  [3:0] abTr  = {abPrev_q, abNow};
  wire  quadInc = (abTr == 4'h1) || (abTr == 4'h7) || (abTr == 4'he) || (abTr == 4'h8);
  wire  quadDec = (abTr == 4'h2) || (abTr == 4'hb) || (abTr == 4'hd) || (abTr == 4'h4);
  wire  cmdInc  = pulseQuadMode ? quadInc : (pin_q[4] & ~pinDly_q[4]);
  wire  cmdDec  = pulseQuadMode ? quadDec : (pin_q[5] & ~pinDly_q[5]);
  wire  signed [39:0] encDelta = encStepFwd ? 40'sh1 : (encStepRev ? -40'sh1 : 40'sh0);
  wire  signed [39:0] cmdDelta = cmdInc ? 40'sh1 : (cmdDec ? -40'sh1 : 40'sh0);

  logic signed [39:0] fbPosRaw_q, fbCum_q, cmdCum_q;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      abPrev_q   <= 2'h0;
      fbPosRaw_q <= 40'sh0;
      fbCum_q    <= 40'sh0;
      cmdCum_q   <= 40'sh0;
    end else begin
      abPrev_q   <= abNow;
      fbPosRaw_q <= fbPosRaw_q + encDelta;
      fbCum_q    <= clrFbCum ? 40'sh0 : fbCum_q + encDelta;
      cmdCum_q   <= clrCmdCum ? 40'sh0 : cmdCum_q + cmdDelta;
    end
  end

  // Frequency: pulses per 10 ms window equal 0.1 kHz units
  logic [19:0]        winCnt_q;
  logic signed [23:0] winAcc_q, freq_q;
  wire  winEnd = (winCnt_q == 20'(FREQ_WIN_CYC - 1));
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      winCnt_q <= 20'h00000;
      winAcc_q <= 24'sh0;
      freq_q   <= 24'sh0;
    end else begin
      winCnt_q <= winEnd ? 20'h00000 : winCnt_q + 20'h1;
      winAcc_q <= winEnd ? 24'sh0 : winAcc_q + 24'(cmdDelta);
      if (winEnd) freq_q <= winAcc_q + 24'(cmdDelta);
    end
  end

  // Homing: count from switch release to the index mark
  logic        homeDly_q, lszRun_q;
  logic [23:0] lszCnt_q, lsz_q;
  wire  homeFall = homeDly_q & ~homeSwitch;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      homeDly_q <= 1'b0;
      lszRun_q  <= 1'b0;
      lszCnt_q  <= 24'h000000;
      lsz_q     <= 24'h000000;
    end else begin
      homeDly_q <= homeSwitch;
      if (homingActive && homeFall) begin
        lszRun_q <= 1'b1;
        lszCnt_q <= 24'h000000;
      end else if (lszRun_q && indexPulse) begin
        lszRun_q <= 1'b0;
        lsz_q    <= lszCnt_q;
      end else if (lszRun_q && (encStepFwd || encStepRev)) begin
        lszCnt_q <= lszCnt_q + 24'h1;
      end
    end
  end

  // ==================================================
  // Two-second peak and extreme capture
  logic [27:0]        tickCnt_q;
  logic signed [15:0] peakRun_q, peak_q;
  logic        [15:0] vMaxRun_q, vMinRun_q, vMax_q, vMin_q;
  wire  tick    = (tickCnt_q == 28'(PEAK_CYC - 1));
  wire  [15:0] trqMagNow = cmdTorque[15] ? 16'(-cmdTorque) : cmdTorque;
  wire  [15:0] trqMagRun = peakRun_q[15] ? 16'(-peakRun_q) : peakRun_q;
  wire  signed [15:0] peakNext = (trqMagNow > trqMagRun) ? cmdTorque : peakRun_q;
  wire  [15:0] vMaxNext = (dcLinkVolt > vMaxRun_q) ? dcLinkVolt : vMaxRun_q;
  wire  [15:0] vMinNext = (dcLinkVolt < vMinRun_q) ? dcLinkVolt : vMinRun_q;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tickCnt_q <= 28'h0000000;
      peakRun_q <= 16'sh0;
      peak_q    <= 16'sh0;
      vMaxRun_q <= 16'h0000;
      vMinRun_q <= 16'hffff;
      vMax_q    <= 16'h0000;
      vMin_q    <= 16'h0000;
    end else begin
      tickCnt_q <= tick ? 28'h0000000 : tickCnt_q + 28'h1;
      peakRun_q <= tick ? 16'sh0 : peakNext;
      vMaxRun_q <= tick ? 16'h0000 : vMaxNext;
      vMinRun_q <= tick ? 16'hffff : vMinNext;
      if (tick) begin
        peak_q <= peakNext;
        vMax_q <= vMaxNext;
        vMin_q <= vMinNext;
      end
    end
  end

  // ==================================================
  // Value selection
  function automatic logic signed [40:0] clampS(input logic signed [40:0] v,
                                                input logic signed [40:0] lo,
                                                input logic signed [40:0] hi);
    clampS = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clampS

  // Gear scaling costs a divider; a zero ratio falls back to raw counts
  wire  gearOk = gearEnable && (gearNum != 16'h0000);
  wire  signed [57:0] gearProd = 58'(fbPosRaw_q) * $signed({1'b0, gearDen});
  wire  signed [57:0] gearQuot = gearProd / $signed({1'b0, gearNum});
  wire  signed [40:0] fbPosDisp = gearOk ? 41'(gearQuot) : 41'(fbPosRaw_q);
  wire  signed [40:0] devDisp   = 41'(cmdPosPulses) - 41'(fbPosRaw_q);
  wire  brkValid = (motorKw10 >= `SMD_BRK_KW10_MIN)
                && (braking_resistor_select == `SMD_BRK_INTERNAL);
  wire  signed [40:0] olVal  = clampS(41'(overload_thermal), 41'sh0, `SMD_PCT_100);
  wire  signed [40:0] brkVal = brkValid ? clampS(41'(brakeRatio), 41'sh0, `SMD_PCT_100)
                                        : 41'sh0;
  wire  signed [40:0] res1Val = res1Found ? clampS(41'(resFreq1), `SMD_RES_MIN, `SMD_RES_MAX)
                                          : `SMD_RES_NONE;
  wire  signed [40:0] res2Val = res2Found ? clampS(41'(resFreq2), `SMD_RES_MIN, `SMD_RES_MAX)
                                          : `SMD_RES_NONE;

  logic signed [40:0] itemVal;
  logic               paged;
  always_comb begin
    itemVal = 41'sh0;
    paged   = 1'b0;
    unique case (item_q)
      `SMD_IT_FBSPD:  itemVal = 41'(fbSpeed);
      `SMD_IT_CMDSPD: itemVal = 41'(cmdSpeed);
      `SMD_IT_CMDTRQ: itemVal = 41'(cmdTorque);
      `SMD_IT_CURR:   itemVal = 41'(motorCurrent);
      `SMD_IT_PEAK:   itemVal = 41'(peak_q);
      `SMD_IT_EFFTRQ: itemVal = 41'(effTorque);
      `SMD_IT_FBPOS:  begin itemVal = fbPosDisp;          paged = 1'b1; end
      `SMD_IT_CMDPOS: begin itemVal = 41'(cmdPosition);   paged = 1'b1; end
      `SMD_IT_DEV:    begin itemVal = devDisp;            paged = 1'b1; end
      `SMD_IT_FREQ:   itemVal = clampS(41'(freq_q), -`SMD_FREQ_LIM, `SMD_FREQ_LIM);
      `SMD_IT_FBCUM:  begin itemVal = 41'(fbCum_q);       paged = 1'b1; end
      `SMD_IT_CMDCUM: begin itemVal = 41'(cmdCum_q);      paged = 1'b1; end
      `SMD_IT_LSZ:    begin
        itemVal = indexEnable ? 41'({1'b0, lsz_q}) : 41'sh0;
        paged   = 1'b1;
      end
      `SMD_IT_INERT:  itemVal = clampS(41'(inertiaRatio), 41'sh0, `SMD_INERT_MAX);
      `SMD_IT_VMAX:   itemVal = clampS(41'(vMax_q), 41'sh0, `SMD_VDC_MAX);
      `SMD_IT_VMIN:   itemVal = clampS(41'(vMin_q), 41'sh0, `SMD_VDC_MAX);
      `SMD_IT_VREF:   itemVal = clampS(41'(speedRefIn), -`SMD_AIN_LIM, `SMD_AIN_LIM);
      `SMD_IT_TORQUE_REF_ANALOG_IN:   itemVal = clampS(41'(torque_ref_analog_in),
                                       -`SMD_AIN_LIM, `SMD_AIN_LIM);
      `SMD_IT_OL:     itemVal = olVal;
      `SMD_IT_BRK:    itemVal = brkVal;
      `SMD_IT_POWER:  itemVal = clampS(41'(motorPower), -`SMD_POWER_MAX,
                                       `SMD_POWER_MAX);
      `SMD_IT_TEMP:   itemVal = clampS(41'(motorTemp), 41'sh0, `SMD_TEMP_MAX);
      `SMD_IT_OVSH:   begin itemVal = 41'(overshoot);     paged = 1'b1; end
      `SMD_IT_SETTLE: itemVal = clampS(41'(settleTime), 41'sh0, `SMD_SETTLE_MAX);
      `SMD_IT_RES1:   itemVal = res1Val;
      `SMD_IT_RES2:   itemVal = res2Val;
      default:        itemVal = 41'sh0;
    endcase
  end

  // ==================================================
  // Formatting
  // Long values are split by magnitude into high and low halves; a negative one blinks the minus.
  logic [25:0] blinkCnt_q;
  logic        blink_q;
  wire  valNeg  = itemVal[40];
  wire  signed [40:0] valMag = valNeg ? -itemVal : itemVal;
  wire  [16:0] hiPart = 17'(valMag / `SMD_HALF_DIV);
  wire  [16:0] loPart = 17'(valMag % `SMD_HALF_DIV);
  wire  [16:0] dataNext = !paged ? 17'(valMag) : (halfHigh_q ? hiPart : loPart);
  wire  [1:0]  tagNext  = !paged ? `SMD_TAG_NONE
                        : (halfHigh_q ? `SMD_TAG_HIGH : `SMD_TAG_LOW);
  wire  minusNext = valNeg && (!paged || blink_q);
  wire  segItem   = (item_q == `SMD_IT_SEQIN) || (item_q == `SMD_IT_SEQOUT);
  wire  [15:0] segNext = (item_q == `SMD_IT_SEQIN) ? sequence_input : sequenceOutput;
  wire  blinkEnd  = (blinkCnt_q == 26'(BLINK_CYC - 1));

  // Blink phase for negative long values
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      blinkCnt_q <= 26'h0000000;
      blink_q    <= 1'b0;
    end else begin
      blinkCnt_q <= blinkEnd ? 26'h0000000 : blinkCnt_q + 26'h1;
      if (blinkEnd) blink_q <= ~blink_q;
    end
  end

  // Display registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      dispItem           <= `SMD_IT_SEQ;
      dispLabel          <= 1'b0;
      dispSeqMode        <= 1'b1;
      dispData           <= 17'h00000;
      dispMinus          <= 1'b0;
      dispHalfTag        <= `SMD_TAG_NONE;
      dispSegments       <= 16'h0000;
      overloadAlarm      <= 1'b0;
      brakeOverheatAlarm <= 1'b0;
    end else begin
      dispItem           <= item_q;
      dispLabel          <= (view_q == ViewLabel);
      dispSeqMode        <= (view_q == ViewSeq);
      dispData           <= (inData && !segItem) ? dataNext : 17'h00000;
      dispMinus          <= inData && !segItem && minusNext;
      dispHalfTag        <= inData ? tagNext : `SMD_TAG_NONE;
      dispSegments       <= (inData && segItem) ? segNext : 16'h0000;
      overloadAlarm      <= (olVal == `SMD_PCT_100);
      brakeOverheatAlarm <= (brkVal == `SMD_PCT_100);
    end
  end

endmodule : smd_monitor
`default_nettype wire

/* test/smd_chk_monitor.sv */
// Checker on the display and alarm outputs
`timescale 1ns/1ps
`default_nettype none
module smd_chk (
  // Clock and reset
  input wire logic               clock,
  input wire logic               nrst,
  // Measurements the display is checked against
  input wire logic signed [15:0] fbSpeed,
  input wire logic        [15:0] sequence_input,
  input wire logic        [15:0] brakeRatio,
  input wire logic        [7:0]  motorKw10,
  input wire logic        [1:0]  braking_resistor_select,
  input wire logic        [15:0] overload_thermal,
  // Watched signals
  input wire logic        [4:0]  dispItem,
  input wire logic               dispLabel,
  input wire logic               dispSeqMode,
  input wire logic        [16:0] dispData,
  input wire logic               dispMinus,
  input wire logic        [1:0]  dispHalfTag,
  input wire logic        [15:0] dispSegments,
  input wire logic               overloadAlarm,
  input wire logic               brakeOverheatAlarm
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // Data view; two cycles of label view bracket an arrow step
  wire logic dv = !dispLabel && !dispSeqMode;
  sequence s_lbl2; dispLabel ##1 dispLabel; endsequence
  item_step_a: assert property (s_lbl2 ##0 $changed(dispItem) |->
    dispItem == $past(dispItem) + 5'h01 || dispItem == $past(dispItem) - 5'h01 ||
    {$past(dispItem), dispItem} inside {10'h381, 10'h03c}) else $error("bad item step");
  item_range_a: assert property (dispLabel |-> dispItem inside {[5'h01:5'h1c]})
    else $error("item out of range");
  seq_blank_a: assert property (dispSeqMode |-> dispItem == 5'h00 && !dispLabel &&
    dispData == 17'h0) else $error("sequence view not blank");
  label_blank_a: assert property (dispLabel |->
    dispData == 17'h0 && dispSegments == 16'h0) else $error("label view shows data");
  tag_paged_a: assert property (dispHalfTag != 2'h0 |-> dv &&
    dispItem inside {5'h07, 5'h08, 5'h09, 5'h0b, 5'h0c, 5'h0d, 5'h19}) else $error("stray tag");
  seg_quiet_a: assert property (!dv |-> dispSegments == 16'h0)
    else $error("segments lit outside data");
  ol_alarm_a: assert property ((overload_thermal >= 16'h64)[*3] |-> overloadAlarm)
    else $error("overload alarm missing");
  ol_quiet_a: assert property ((overload_thermal < 16'h64)[*3] |-> !overloadAlarm)
    else $error("overload alarm false");
  // Speed shows its magnitude, with a steady minus when reversing
  spd_show_a: assert property (dv && dispItem == 5'h01 |->
    dispMinus == ($past(fbSpeed) < 16'sh0) && dispData == ($past(fbSpeed) < 16'sh0 ?
    17'h0 - 17'($past(fbSpeed)) : 17'($past(fbSpeed)))) else $error("speed shown wrong");
  seg_show_a: assert property (dv && dispItem == 5'h13 |->
    dispSegments == $past(sequence_input) && dispData == 17'h0)
    else $error("input segments wrong");
  // Alarm only for a large enough motor on the internal resistor
  brk_alarm_a: assert property (1'b1 |=> brakeOverheatAlarm ==
    ($past(motorKw10) >= 8'h04 && $past(braking_resistor_select) == 2'h1 &&
    $past(brakeRatio) >= 16'h64)) else $error("brake alarm wrong");
endmodule : smd_chk
`default_nettype wire

/* test/smd_keypad.sv */
// Keypad model: the operator presses and releases keys
`timescale 1ns/1ps
`default_nettype none
module smd_keypad (
  // Clock
  input  wire logic clock,
  // Keys toward the amplifier
  output var logic  keyUp,
  output var logic  keyDown,
  output var logic  keyShift,
  output var logic  menu_back_key
);
  initial {keyUp, keyDown, keyShift, menu_back_key} = 4'h0;
  // Hold a pattern n cycles, then idle long enough for the key filter to settle
  task automatic press(input logic [3:0] k, input int n);
    {keyUp, keyDown, keyShift, menu_back_key} = k;
    repeat (n) @(negedge clock);
    {keyUp, keyDown, keyShift, menu_back_key} = 4'h0;
    repeat (12) @(negedge clock);
  endtask : press
endmodule : smd_keypad
`default_nettype wire

/* test/servo_monitor_display_tb.sv */
// Self-checking bench for the monitor display block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module servo_monitor_display_tb;
  logic clock, nrst, pulseInA, pulseInB, pulseQuadMode, encStepFwd, encStepRev, gearEnable;
  logic homingActive, homeSwitch, indexPulse, indexEnable, res1Found, res2Found, keyUp, keyDown;
  logic keyShift, menu_back_key, overloadAlarm, brakeOverheatAlarm, dispLabel, dispSeqMode;
  logic dispMinus;
  logic signed [15:0] fbSpeed, cmdSpeed, cmdTorque, motorCurrent, effTorque, speedRefIn;
  logic signed [15:0] torque_ref_analog_in, motorPower;
  logic [15:0] gearNum, gearDen, inertiaRatio, dcLinkVolt, sequence_input, sequenceOutput;
  logic [15:0] brakeRatio;
  logic [15:0] overload_thermal, motorTemp, settleTime, resFreq1, resFreq2, dispSegments;
  logic signed [39:0] cmdPosition, cmdPosPulses, overshoot;
  logic [7:0] motorKw10;
  logic [1:0] braking_resistor_select, dispHalfTag;
  logic [4:0] power_on_display_select, dispItem;
  logic [16:0] dispData;
  logic [447:0] rv;
  logic [26:0] q[$];
  logic [26:0] expV;
  int seed = 32'hf032;
  int n_fail = 0;
  int compares = 0;
  wire logic [26:0] obs = {dispSeqMode, dispLabel, dispItem, dispData, dispMinus, dispHalfTag};
  // ==================================================
  // Design, keypad model and clock
  smd_monitor #(.HOLD_CYC(20), .PEAK_CYC(50), .FREQ_WIN_CYC(16), .BLINK_CYC(8)) u_dut (.*);
  smd_keypad u_kp (.*);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Fresh random measurements every falling edge, from time zero
  initial forever begin
    for (int i = 0; i < 14; i++) rv[i*32 +: 32] = $random(seed);
    {fbSpeed, cmdSpeed, cmdTorque, motorCurrent, effTorque, gearEnable, gearNum, gearDen,
     cmdPosition, cmdPosPulses, overshoot, homingActive, homeSwitch, indexPulse, indexEnable,
     inertiaRatio, dcLinkVolt, speedRefIn, torque_ref_analog_in, sequence_input, sequenceOutput,
     brakeRatio, motorKw10, braking_resistor_select, motorPower, motorTemp, settleTime,
     resFreq1, resFreq2, res1Found, res2Found, pulseInA, pulseInB, pulseQuadMode} = rv[443:0];
    overload_thermal = {9'h0, rv[446:440]}; // Straddles the alarm level of 100
    @(negedge clock);
  end
  // ==================================================
  // Scoreboard: oldest note against the settled display
  task automatic ex(input logic [26:0] v);
    q.push_back(v);
    repeat (2) @(negedge clock);
  endtask : ex
  // Pop once, so a mismatch report cannot eat the next note
  always @(negedge clock) if (q.size() > 0) begin
    expV = q.pop_front();
    `CHK(obs, expV)
  end
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  // Watchdog: the sequence needs about 750 cycles, so 10000 means a hang
  initial begin
    #100000;
    n_fail++;
    results;
  end
  // ==================================================
  // Main sequence; key codes are up 8, down 4, shift 2, back 1
  initial begin
    {nrst, encStepFwd, encStepRev} = 3'h0;
    power_on_display_select = 5'h01;
    repeat (3) @(negedge clock);
    nrst = 1'b1;
    repeat (4) @(negedge clock);
    ex({2'b01, 5'h01, 20'h0});
    u_kp.press(4'h4, 8);
    ex({2'b01, 5'h1c, 20'h0});
    u_kp.press(4'h8, 8);
    ex({2'b01, 5'h01, 20'h0});
    repeat (10) u_kp.press(4'h8, 8);
    // Five steps forward, then two back, with no gap between them
    for (int i = 0; i < 7; i++) begin
      {encStepFwd, encStepRev} = (i < 5) ? 2'b10 : 2'b01;
      @(negedge clock);
    end
    {encStepFwd, encStepRev} = 2'b00;
    u_kp.press(4'h2, 30);
    ex({2'b00, 5'h0b, 17'h3, 3'h2});
    u_kp.press(4'hc, 30);
    ex({2'b00, 5'h0b, 17'h0, 3'h2});
    u_kp.press(4'h2, 8);
    ex({2'b00, 5'h0b, 17'h0, 3'h1});
    u_kp.press(4'h1, 8);
    ex({2'b01, 5'h0b, 20'h0});
    u_kp.press(4'h1, 8);
    ex({2'b10, 5'h00, 20'h0});
    // Speed in data view, then ten items down to the input signals
    u_kp.press(4'h1, 8);
    ex({2'b01, 5'h01, 20'h0});
    u_kp.press(4'h2, 30);
    u_kp.press(4'h1, 8);
    repeat (10) u_kp.press(4'h4, 8);
    ex({2'b01, 5'h13, 20'h0});
    u_kp.press(4'h2, 30);
    ex({2'b00, 5'h13, 20'h0});
    results;
  end
endmodule : servo_monitor_display_tb
bind smd_monitor smd_chk u_chk (.*);
`default_nettype wire
